// [design/axis_limit_safe_zone.sv]
// Travel limits, homing reference select, switch-exit slowdown and
// safe-zone output for four axes. Assumes positions, homed and enable
// flags come from the motion core, synchronous to ref_clk.
//
// Overview of operation
// RL1 - CCW soft limit armed only after homing
// RL2 - CCW bound signed 48 bits, most negative
// RL3 - CW soft limit armed only after homing
// RL4 - CW bound signed 48 bits, most positive
// RL5 - Soft limit faults enabled by default
// RL6 - CW, CCW and home switch per axis
// RL7 - Home switch option: seek home switch
// RL8 - Option clear: directional limit is reference
// RL9 - Reference limit raises no fault while homing
// RL10 - Home switch option clear after reset
// RL11 - One zone window per axis, homed position
// RL12 - Inside needs enabled, homed, within bounds
// RL13 - Selected output sinks when all inside
// RL14 - Both bounds zero excludes the axis
// RL15 - Switch exit slowdown distance, default 750
// RL16 - Zero distance disables the slowdown
// RL17 - Switch lines idle high, pulled up
// RL18 - Limit polarity normally open or closed
// RL19 - Armed soft limit overrun raises fault
//
// Our own choices: the plain strobed port and the register addresses.
`timescale 1ns/1ps
`default_nettype none

module axis_limit_safe_zone (
  input  wire logic              ref_clk,           // 25 MHz clock
  input  wire logic              sys_rst,           // Sync reset, high
  input  wire logic [7:0]        reg_addr,          // Register word address
  input  wire logic [31:0]       reg_wdata,         // Write data
  input  wire logic              reg_wr,            // Write strobe
  input  wire logic              reg_rd,            // Read strobe
  output logic      [31:0]       reg_rdata,         // Read data, next cycle
  output logic                   irq,               // Level interrupt
  input  wire logic [3:0][47:0]  axis_pos,          // Position from home
  input  wire logic [3:0]        axis_homed,        // Axis has homed
  input  wire logic [3:0]        axis_enabled,      // Axis enabled
  input  wire logic [3:0]        home_cycle_active, // Home cycle running
  input  wire logic [3:0]        cw_limit_in,       // Raw CW switch
  input  wire logic [3:0]        ccw_limit_in,      // Raw CCW switch
  input  wire logic [3:0]        home_switch_in,    // Raw home switch, NO
  output logic      [3:0]        home_ref_hit,      // Homing reference seen
  output logic      [3:0]        decel_active,      // Switch exit slowdown
  output logic      [7:0]        safe_zone_sink     // High: output sinks
);

  typedef struct packed {
    logic [3:0][47:0] ccw_bound;
    logic [3:0][47:0] cw_bound;
    logic [3:0][47:0] zone_lo;
    logic [3:0][47:0] zone_hi;
    logic [3:0][47:0] exit_pos;
    logic [3:0][22:0] decel_dist;
    logic [3:0][2:0]  axis_cfg;
    logic [15:0]      status;
    logic [15:0]      irq_mask;
    logic [15:0]      fault_en;
    logic [2:0]       zone_sel;
    logic [3:0]       ref_prev;
    logic [3:0]       decel_active;
    logic [3:0]       home_ref_hit;
    logic [7:0]       safe_sink;
    logic             irq;
    logic [31:0]      rdata;
  } state_t;

  state_t     st_reg;
  state_t     st_next;
  logic [3:0] cw_act;
  logic [3:0] ccw_act;
  logic [3:0] ref_act;
  logic [3:0] zone_part;
  logic [3:0] zone_in;
  logic [3:0] dist_done;
  logic [15:0] evt;
  logic [1:0] ax;
  logic       ax_hit;
  logic       zone_ok;

  ////////////////////////////////////////////////////////////////////
  // Per-axis comparisons
  genvar a;
  generate
    for (a = 0; a < axis_limit_pkg::NUM_AXES; a++) begin : g_axis
      logic        pol_nc;
      logic        use_home;
      logic        dir_ccw;
      logic [47:0] delta;
      logic [47:0] mag;
      assign pol_nc   = st_reg.axis_cfg[a][axis_limit_pkg::CFG_POL_NC];
      assign use_home = st_reg.axis_cfg[a][axis_limit_pkg::CFG_HOME_SW];
      assign dir_ccw  = st_reg.axis_cfg[a][axis_limit_pkg::CFG_DIR_CCW];
      // RL17 - pulled-up lines
      // RL18 - polarity decode: a closed NO switch pulls the line low
      assign cw_act[a]  = pol_nc ? cw_limit_in[a] : ~cw_limit_in[a];
      assign ccw_act[a] = pol_nc ? ccw_limit_in[a] : ~ccw_limit_in[a];
      // RL6 - three switches
      // RL7 RL8 - homing reference select
      assign ref_act[a] = use_home ? ~home_switch_in[a]
                        : (dir_ccw ? ccw_act[a] : cw_act[a]);
      // RL19 - soft limit overrun
      // RL1 RL3 - armed only once homed
      assign evt[a*4+axis_limit_pkg::FLT_SOFT_CW] = axis_homed[a] &&
        ($signed(axis_pos[a]) > $signed(st_reg.cw_bound[a]));
      assign evt[a*4+axis_limit_pkg::FLT_SOFT_CCW] = axis_homed[a] &&
        ($signed(axis_pos[a]) < $signed(st_reg.ccw_bound[a]));
      // RL9 - reference limit quiet while homing
      assign evt[a*4+axis_limit_pkg::FLT_HW_CW] = cw_act[a] &&
        !(home_cycle_active[a] && !use_home && !dir_ccw);
      assign evt[a*4+axis_limit_pkg::FLT_HW_CCW] = ccw_act[a] &&
        !(home_cycle_active[a] && !use_home && dir_ccw);
      // RL14 - zero window excluded
      assign zone_part[a] = (|st_reg.zone_lo[a]) || (|st_reg.zone_hi[a]);
      // RL11 RL12 - window test
      assign zone_in[a] = axis_enabled[a] && axis_homed[a] &&
        ($signed(axis_pos[a]) >= $signed(st_reg.zone_lo[a])) &&
        ($signed(axis_pos[a]) <= $signed(st_reg.zone_hi[a]));
      // Distance travelled since leaving the switch
      assign delta = axis_pos[a] - st_reg.exit_pos[a];
      assign mag   = delta[47] ? (48'h0 - delta) : delta;
      assign dist_done[a] = mag >= {25'h0, st_reg.decel_dist[a]};
    end
  endgenerate

  // RL13 - every participant inside; no participant means no output
  assign zone_ok = (|zone_part) && (&(~zone_part | zone_in));
  assign ax      = 2'(reg_addr[7:4] - axis_limit_pkg::AXIS_FIRST);
  assign ax_hit  = (reg_addr[7:4] >= axis_limit_pkg::AXIS_FIRST) &&
                   (reg_addr[7:4] <= axis_limit_pkg::AXIS_LAST);

  ////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    logic [15:0] clr;
    logic [3:0]  off;
    st_next = st_reg;
    clr     = 16'h0000;
    off     = reg_addr[3:0];
    // Register writes
    if (reg_wr) begin
      if (reg_addr == axis_limit_pkg::ADDR_STATUS) begin
        clr = reg_wdata[15:0];
      end else if (reg_addr == axis_limit_pkg::ADDR_IRQ_MASK) begin
        st_next.irq_mask = reg_wdata[15:0];
      end else if (reg_addr == axis_limit_pkg::ADDR_FAULT_EN) begin
        st_next.fault_en = reg_wdata[15:0];
      end else if (reg_addr == axis_limit_pkg::ADDR_ZONE_CFG) begin
        st_next.zone_sel = reg_wdata[2:0];
      end else if (ax_hit) begin
        // RL2 RL4 - full signed 48-bit bounds over two words
        if (off == axis_limit_pkg::OFF_CCW_LO) begin
          st_next.ccw_bound[ax][31:0] = reg_wdata;
        end else if (off == axis_limit_pkg::OFF_CCW_HI) begin
          st_next.ccw_bound[ax][47:32] = reg_wdata[15:0];
        end else if (off == axis_limit_pkg::OFF_CW_LO) begin
          st_next.cw_bound[ax][31:0] = reg_wdata;
        end else if (off == axis_limit_pkg::OFF_CW_HI) begin
          st_next.cw_bound[ax][47:32] = reg_wdata[15:0];
        end else if (off == axis_limit_pkg::OFF_ZLO_LO) begin
          st_next.zone_lo[ax][31:0] = reg_wdata;
        end else if (off == axis_limit_pkg::OFF_ZLO_HI) begin
          st_next.zone_lo[ax][47:32] = reg_wdata[15:0];
        end else if (off == axis_limit_pkg::OFF_ZHI_LO) begin
          st_next.zone_hi[ax][31:0] = reg_wdata;
        end else if (off == axis_limit_pkg::OFF_ZHI_HI) begin
          st_next.zone_hi[ax][47:32] = reg_wdata[15:0];
        end else if (off == axis_limit_pkg::OFF_DECEL) begin
          st_next.decel_dist[ax] = reg_wdata[22:0];
        end else if (off == axis_limit_pkg::OFF_CFG) begin
          st_next.axis_cfg[ax] = reg_wdata[2:0];
        end
      end
    end
    // RL5 RL19 - enabled events latch; a new event beats the clear
    st_next.status = (st_reg.status & ~clr) | (evt & st_reg.fault_en);
    st_next.irq    = |(st_next.status & st_next.irq_mask);
    // Register reads, unmapped addresses read zero
    st_next.rdata = 32'h0000_0000;
    if (reg_rd) begin
      if (reg_addr == axis_limit_pkg::ADDR_STATUS) begin
        st_next.rdata = {16'h0000, st_reg.status};
      end else if (reg_addr == axis_limit_pkg::ADDR_IRQ_MASK) begin
        st_next.rdata = {16'h0000, st_reg.irq_mask};
      end else if (reg_addr == axis_limit_pkg::ADDR_FAULT_EN) begin
        st_next.rdata = {16'h0000, st_reg.fault_en};
      end else if (reg_addr == axis_limit_pkg::ADDR_ZONE_CFG) begin
        st_next.rdata = {29'h0, st_reg.zone_sel};
      end else if (reg_addr == axis_limit_pkg::ADDR_LIVE) begin
        st_next.rdata = {11'h0, zone_ok, st_reg.decel_active, zone_in,
                         ref_act, ccw_act, cw_act};
      end else if (ax_hit) begin
        if (off == axis_limit_pkg::OFF_CCW_LO) begin
          st_next.rdata = st_reg.ccw_bound[ax][31:0];
        end else if (off == axis_limit_pkg::OFF_CCW_HI) begin
          st_next.rdata = {16'h0000, st_reg.ccw_bound[ax][47:32]};
        end else if (off == axis_limit_pkg::OFF_CW_LO) begin
          st_next.rdata = st_reg.cw_bound[ax][31:0];
        end else if (off == axis_limit_pkg::OFF_CW_HI) begin
          st_next.rdata = {16'h0000, st_reg.cw_bound[ax][47:32]};
        end else if (off == axis_limit_pkg::OFF_ZLO_LO) begin
          st_next.rdata = st_reg.zone_lo[ax][31:0];
        end else if (off == axis_limit_pkg::OFF_ZLO_HI) begin
          st_next.rdata = {16'h0000, st_reg.zone_lo[ax][47:32]};
        end else if (off == axis_limit_pkg::OFF_ZHI_LO) begin
          st_next.rdata = st_reg.zone_hi[ax][31:0];
        end else if (off == axis_limit_pkg::OFF_ZHI_HI) begin
          st_next.rdata = {16'h0000, st_reg.zone_hi[ax][47:32]};
        end else if (off == axis_limit_pkg::OFF_DECEL) begin
          st_next.rdata = {9'h000, st_reg.decel_dist[ax]};
        end else if (off == axis_limit_pkg::OFF_CFG) begin
          st_next.rdata = {29'h0, st_reg.axis_cfg[ax]};
        end
      end
    end
    // Homing reference and switch-exit slowdown per axis
    for (int i = 0; i < axis_limit_pkg::NUM_AXES; i++) begin
      st_next.ref_prev[i] = ref_act[i];
      // RL7 RL8 - reference reached during homing
      st_next.home_ref_hit[i] = home_cycle_active[i] && ref_act[i];
      if (!home_cycle_active[i]) begin
        st_next.decel_active[i] = 1'b0;
      // RL15 RL16 - start on switch release, skipped for zero distance
      end else if (st_reg.ref_prev[i] && !ref_act[i] &&
                   (st_reg.decel_dist[i] != 23'h000000)) begin
        st_next.decel_active[i] = 1'b1;
        st_next.exit_pos[i]     = axis_pos[i];
      end else if (st_reg.decel_active[i] && dist_done[i]) begin
        st_next.decel_active[i] = 1'b0;
      end
    end
    // RL13 - one-hot sink on the chosen output line
    st_next.safe_sink = zone_ok ? (8'h01 << st_reg.zone_sel) : 8'h00;
  end

  ////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      st_reg              <= '0;
      // RL2 RL4 - widest bounds so nothing trips before setup
      st_reg.ccw_bound    <= {4{axis_limit_pkg::CCW_RST}};
      st_reg.cw_bound     <= {4{axis_limit_pkg::CW_RST}};
      st_reg.zone_lo      <= {4{axis_limit_pkg::ZONE_RST}};
      st_reg.zone_hi      <= {4{axis_limit_pkg::ZONE_RST}};
      st_reg.decel_dist   <= {4{axis_limit_pkg::DECEL_RST}};
      // RL10 - home switch option clear
      st_reg.axis_cfg     <= {4{axis_limit_pkg::CFG_RST}};
      st_reg.fault_en     <= axis_limit_pkg::FAULT_EN_RST;
      st_reg.irq_mask     <= axis_limit_pkg::IRQ_MASK_RST;
      st_reg.zone_sel     <= axis_limit_pkg::ZONE_SEL_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  assign reg_rdata      = st_reg.rdata;
  assign irq            = st_reg.irq;
  assign home_ref_hit   = st_reg.home_ref_hit;
  assign decel_active   = st_reg.decel_active;
  assign safe_zone_sink = st_reg.safe_sink;

  ////////////////////////////////////////////////////////////////////
  // Checks
  AST_SOFT_UNARMED: assert property (@(posedge ref_clk) disable iff (sys_rst) // RL1
    (axis_homed == 4'h0 && (st_reg.status & axis_limit_pkg::SOFT_FLT_MASK) == 16'h0)
    |=> ((st_reg.status & axis_limit_pkg::SOFT_FLT_MASK) == 16'h0))
    else $error("soft fault raised before homing");
  AST_SOFT_CW_TRIP: assert property (@(posedge ref_clk) disable iff (sys_rst) // RL19
    (axis_homed[0] && st_reg.fault_en[0] &&
     $signed(axis_pos[0]) > $signed(st_reg.cw_bound[0])) |=> st_reg.status[0])
    else $error("cw soft overrun not flagged");
  AST_BOUND_RST: assert property (@(posedge ref_clk) disable iff (sys_rst) // RL2
    $fell(sys_rst) |-> (st_reg.ccw_bound[1] == axis_limit_pkg::CCW_RST &&
                        st_reg.cw_bound[2] == axis_limit_pkg::CW_RST))
    else $error("soft bounds wrong after reset");
  AST_CFG_RST: assert property (@(posedge ref_clk) disable iff (sys_rst) // RL10
    $fell(sys_rst) |-> (st_reg.axis_cfg[3][0] == 1'b0 &&
      st_reg.fault_en == 16'hffff && st_reg.decel_dist[0] == 23'h0002ee))
    else $error("config wrong after reset");
  AST_REF_QUIET: assert property (@(posedge ref_clk) disable iff (sys_rst) // RL9
    (home_cycle_active[2] && st_reg.axis_cfg[2] == 3'h4 && ccw_act[2] &&
     !st_reg.status[11] && !reg_wr) |=> !st_reg.status[11])
    else $error("reference limit faulted while homing");
  AST_HOME_HIT: assert property (@(posedge ref_clk) disable iff (sys_rst) // RL7
    (home_cycle_active[2] && st_reg.axis_cfg[2][0] && !home_switch_in[2])
    |=> home_ref_hit[2])
    else $error("home switch not taken as reference");
  AST_ZONE_OFF: assert property (@(posedge ref_clk) disable iff (sys_rst) // RL14
    (zone_part == 4'h0) |=> (safe_zone_sink == 8'h00))
    else $error("sink active with no participant");
  AST_ZONE_ON: assert property (@(posedge ref_clk) disable iff (sys_rst) // RL13
    (zone_ok && !reg_wr) |=> (safe_zone_sink == (8'h01 << st_reg.zone_sel)))
    else $error("safe zone output not driven");
  AST_DECEL_OFF: assert property (@(posedge ref_clk) disable iff (sys_rst) // RL16
    (home_cycle_active[2] && st_reg.decel_dist[2] == 23'h0 && !st_reg.decel_active[2])
    |=> !decel_active[2])
    else $error("slowdown with zero distance");
  AST_DECEL_ON: assert property (@(posedge ref_clk) disable iff (sys_rst) // RL15
    (home_cycle_active[2] && st_reg.ref_prev[2] && !ref_act[2] &&
     st_reg.decel_dist[2] != 23'h0) |=> (decel_active[2] &&
     st_reg.exit_pos[2] == $past(axis_pos[2])))
    else $error("slowdown not started on switch exit");

endmodule // axis_limit_safe_zone

`default_nettype wire

// [pkg/axis_limit_pkg.sv]
// Constants for the four-axis travel-limit and safe-zone block.
// Assumes a word-addressed register port, 8-bit address, 32-bit data.
package axis_limit_pkg;
  localparam int NUM_AXES = 4;
  localparam int POS_W    = 48;
  localparam int DIST_W   = 23;
  localparam int FLT_W    = 16;
  // Global registers
  localparam logic [7:0] ADDR_STATUS   = 8'h00;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h01;
  localparam logic [7:0] ADDR_FAULT_EN = 8'h02;
  localparam logic [7:0] ADDR_ZONE_CFG = 8'h03;
  localparam logic [7:0] ADDR_LIVE     = 8'h04;
  // Axis n occupies addresses with upper nibble n+1
  localparam logic [3:0] AXIS_FIRST  = 4'h1;
  localparam logic [3:0] AXIS_LAST   = 4'h4;
  localparam logic [3:0] OFF_CCW_LO  = 4'h0;
  localparam logic [3:0] OFF_CCW_HI  = 4'h1;
  localparam logic [3:0] OFF_CW_LO   = 4'h2;
  localparam logic [3:0] OFF_CW_HI   = 4'h3;
  localparam logic [3:0] OFF_ZLO_LO  = 4'h4;
  localparam logic [3:0] OFF_ZLO_HI  = 4'h5;
  localparam logic [3:0] OFF_ZHI_LO  = 4'h6;
  localparam logic [3:0] OFF_ZHI_HI  = 4'h7;
  localparam logic [3:0] OFF_DECEL   = 4'h8;
  localparam logic [3:0] OFF_CFG     = 4'h9;
  // Axis config bits
  localparam int CFG_HOME_SW = 0;
  localparam int CFG_POL_NC  = 1;
  localparam int CFG_DIR_CCW = 2;
  // Fault bits per axis, four per axis
  localparam int FLT_SOFT_CW  = 0;
  localparam int FLT_SOFT_CCW = 1;
  localparam int FLT_HW_CW    = 2;
  localparam int FLT_HW_CCW   = 3;
  localparam logic [15:0] SOFT_FLT_MASK = 16'h3333;
  // Values after reset
  localparam logic [47:0] CCW_RST      = 48'h8000_0000_0000;
  localparam logic [47:0] CW_RST       = 48'h7fff_ffff_ffff;
  localparam logic [47:0] ZONE_RST     = 48'h0000_0000_0000;
  localparam logic [22:0] DECEL_RST    = 23'h0002ee;
  localparam logic [2:0]  CFG_RST      = 3'h4;
  localparam logic [15:0] FAULT_EN_RST = 16'hffff;
  localparam logic [15:0] IRQ_MASK_RST = 16'h0000;
  localparam logic [2:0]  ZONE_SEL_RST = 3'h0;
endpackage

// [testbench/switch_model.sv]
// Far-side model: axis limit and home switches, safe-zone output pins.
// Assumes the bench commands switch actuation as plain levels.
`timescale 1ns/1ps
`default_nettype none

module switch_model (
  input  wire logic [3:0] cw_act,    // CW switch actuated
  input  wire logic [3:0] ccw_act,   // CCW switch actuated
  input  wire logic [3:0] home_act,  // Home switch actuated
  input  wire logic [3:0] pol_nc,    // Limit switches normally closed
  input  wire logic [7:0] sink,      // Output transistor on
  output logic      [3:0] cw_line,   // CW line to the block
  output logic      [3:0] ccw_line,  // CCW line to the block
  output logic      [3:0] home_line, // Home line, normally open
  output logic      [7:0] zone_line  // Output pins with pull-up
);
  ////////////////////////////////////////////////////////////////////////////////
  // switch line levels
  // An open contact reads high through the pull-up; a closed switch opens when hit
  assign cw_line   = cw_act ^ ~pol_nc;
  assign ccw_line  = ccw_act ^ ~pol_nc;
  assign home_line = ~home_act;
  // sinking output
  // A pin that is not sunk floats up to the pull-up, never holds its old level
  assign zone_line = ~sink;
endmodule // switch_model

`default_nettype wire

// [testbench/axis_limit_safe_zone_tb.sv]
// Self-checking bench for the travel-limit and safe-zone block.
// Assumes the switch model on the far side and a 25 MHz clock.
`timescale 1ns/1ps
`default_nettype none

module axis_limit_safe_zone_tb;
  logic             ref_clk = 1'b0;
  logic             sys_rst = 1'b1;
  logic [7:0]       reg_addr = 8'h00;
  logic [31:0]      reg_wdata = 32'h0;
  logic             reg_wr = 1'b0;
  logic             reg_rd = 1'b0;
  logic [31:0]      reg_rdata;
  logic             irq;
  logic [3:0][47:0] pos = '0;
  logic [3:0]       homed = 4'h0, en = 4'h0, hca = 4'h0, pol = 4'h0;
  logic [3:0]       cw_act = 4'h0, ccw_act = 4'h0, home_act = 4'h0;
  logic [3:0]       cw_line, ccw_line, home_line, ref_hit, decel;
  logic [7:0]       sink, zone_line;
  logic [7:0]       row_a [12];
  logic [31:0]      row_v [12];
  int               n_errors = 0;
  int               num_checks = 0;
  int               cycles = 0;

  ////////////////////////////////////////////////////////////////////////////////
  // Clock, block and far side
  always #20 ref_clk = ~ref_clk;

  axis_limit_safe_zone i_dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .irq(irq), .axis_pos(pos), .axis_homed(homed), .axis_enabled(en),
    .home_cycle_active(hca), .cw_limit_in(cw_line), .ccw_limit_in(ccw_line),
    .home_switch_in(home_line), .home_ref_hit(ref_hit), .decel_active(decel),
    .safe_zone_sink(sink));

  switch_model i_far (.cw_act(cw_act), .ccw_act(ccw_act), .home_act(home_act),
    .pol_nc(pol), .sink(sink), .cw_line(cw_line), .ccw_line(ccw_line),
    .home_line(home_line), .zone_line(zone_line));

  ////////////////////////////////////////////////////////////////////////////////
  // Helpers: bus cycles, comparison, verdict
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask

  // Low word first; the intermediate soft bound is never tighter than the final one here
  task automatic wr48(input logic [7:0] a, input logic [47:0] v);
    wr(a, v[31:0]);
    wr(a + 8'h01, {16'h0, v[47:32]});
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    chk({16'h0, reg_rdata}, {16'h0, e});
  endtask

  function automatic logic [7:0] ax(input logic [3:0] n, input logic [3:0] off);
    return {n + 4'h1, off};
  endfunction

  task automatic summarize;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // Hang guard, far above the fewer than two hundred cycles the tests need
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_errors++;
      summarize();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    row_a = '{ax(4'h0, axis_limit_pkg::OFF_CCW_LO), ax(4'h0, axis_limit_pkg::OFF_CCW_HI),
      ax(4'h3, axis_limit_pkg::OFF_CW_LO), ax(4'h3, axis_limit_pkg::OFF_CW_HI),
      ax(4'h1, axis_limit_pkg::OFF_ZLO_LO), ax(4'h2, axis_limit_pkg::OFF_ZHI_HI),
      ax(4'h2, axis_limit_pkg::OFF_DECEL), ax(4'h1, axis_limit_pkg::OFF_CFG),
      axis_limit_pkg::ADDR_FAULT_EN, axis_limit_pkg::ADDR_IRQ_MASK,
      axis_limit_pkg::ADDR_ZONE_CFG, 8'hff};
    row_v = '{32'h0, 32'h8000, 32'hffff_ffff, 32'h7fff, 32'h0, 32'h0, 32'h2ee, 32'h4,
      32'hffff, 32'h0, 32'h0, 32'h0};
    tick(6);
    chk({irq, sink, ref_hit, decel}, 48'h0);
    sys_rst <= 1'b0;
    for (int i = 0; i < 12; i++)
      rdc(row_a[i], row_v[i]);
    // Soft limits: disarmed until homed, then sticky status and interrupt
    wr48(ax(4'h0, axis_limit_pkg::OFF_CW_LO), 48'h64);
    pos[0] <= 48'hc8;
    tick(3);
    rdc(axis_limit_pkg::ADDR_STATUS, 32'h0);
    homed[0] <= 1'b1;
    tick(3);
    rdc(axis_limit_pkg::ADDR_STATUS, 32'h1);
    wr(axis_limit_pkg::ADDR_IRQ_MASK, 32'h1);
    wr(axis_limit_pkg::ADDR_STATUS, 32'h1);
    tick(3);
    chk(irq, 1'b1);
    rdc(axis_limit_pkg::ADDR_STATUS, 32'h1);
    pos[0] <= 48'h0;
    wr(axis_limit_pkg::ADDR_STATUS, 32'h1);
    tick(3);
    chk(irq, 1'b0);
    wr48(ax(4'h1, axis_limit_pkg::OFF_CCW_LO), 48'hffff_ffff_ff9c);
    pos[1] <= 48'hffff_ffff_ff38;
    tick(3);
    rdc(axis_limit_pkg::ADDR_STATUS, 32'h0);
    homed[1] <= 1'b1;
    tick(3);
    rdc(axis_limit_pkg::ADDR_STATUS, 32'h20);
    wr(axis_limit_pkg::ADDR_FAULT_EN, 32'hffdf);
    wr(axis_limit_pkg::ADDR_STATUS, 32'hffff);
    tick(3);
    rdc(axis_limit_pkg::ADDR_STATUS, 32'h0);
    wr(axis_limit_pkg::ADDR_FAULT_EN, 32'hffff);
    pos[1] <= 48'h0;
    // Homing on the CCW limit, switch exit slowdown
    hca[2] <= 1'b1;
    ccw_act[2] <= 1'b1;
    tick(3);
    chk(ref_hit, 4'h4);
    rdc(axis_limit_pkg::ADDR_STATUS, 32'h0);
    ccw_act[2] <= 1'b0;
    tick(3);
    chk(decel, 4'h4);
    pos[2] <= 48'h2ed;
    tick(3);
    chk(decel, 4'h4);
    pos[2] <= 48'h2ee;
    tick(3);
    chk(decel, 4'h0);
    home_act[2] <= 1'b1;
    tick(3);
    chk(ref_hit, 4'h0);
    wr(ax(4'h2, axis_limit_pkg::OFF_CFG), 32'h5);
    wr(ax(4'h2, axis_limit_pkg::OFF_DECEL), 32'h0);
    tick(3);
    chk(ref_hit, 4'h4);
    home_act[2] <= 1'b0;
    tick(3);
    chk(decel, 4'h0);
    hca[2] <= 1'b0;
    ccw_act[2] <= 1'b1;
    tick(3);
    rdc(axis_limit_pkg::ADDR_STATUS, 32'h800);
    ccw_act[2] <= 1'b0;
    // Normally closed limit on axis 3
    pol[3] <= 1'b1;
    wr(ax(4'h3, axis_limit_pkg::OFF_CFG), 32'h6);
    wr(axis_limit_pkg::ADDR_STATUS, 32'hffff);
    tick(3);
    rdc(axis_limit_pkg::ADDR_STATUS, 32'h0);
    cw_act[3] <= 1'b1;
    tick(3);
    rdc(axis_limit_pkg::ADDR_STATUS, 32'h4000);
    // Safe zone on axis 0, others excluded by zero bounds
    wr48(ax(4'h0, axis_limit_pkg::OFF_ZLO_LO), 48'hffff_ffff_fff6);
    wr48(ax(4'h0, axis_limit_pkg::OFF_ZHI_LO), 48'ha);
    en[0] <= 1'b1;
    tick(3);
    chk(sink, 8'h01);
    wr(axis_limit_pkg::ADDR_ZONE_CFG, 32'h3);
    tick(3);
    chk(zone_line, 8'hf7);
    pos[0] <= 48'hb;
    tick(3);
    chk(sink, 8'h00);
    pos[0] <= 48'ha;
    tick(3);
    chk(sink, 8'h08);
    homed[0] <= 1'b0;
    tick(3);
    chk(sink, 8'h00);
    homed[0] <= 1'b1;
    en[0] <= 1'b0;
    tick(3);
    chk(sink, 8'h00);
    en[0] <= 1'b1;
    wr48(ax(4'h1, axis_limit_pkg::OFF_ZHI_LO), 48'h5);
    tick(3);
    chk(sink, 8'h00);
    // Reset in mid-run returns outputs and bounds to their defaults
    sys_rst <= 1'b1;
    tick(2);
    chk({irq, sink}, 48'h0);
    sys_rst <= 1'b0;
    rdc(ax(4'h0, axis_limit_pkg::OFF_CW_LO), 32'hffff_ffff);
    summarize();
  end
endmodule // axis_limit_safe_zone_tb

`default_nettype wire
